/* File: logic/sbt_consts.svh */
// constants for the sixteen bit timer counter: offsets, fields, resets
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH
// register indices as printed; byte address is four times the index
`define SBT_IDX_INTCTL 8'h0B
`define SBT_IDX_FLAGS 8'h0C
`define SBT_IDX_CNT_LO 8'h0E
`define SBT_IDX_CNT_HI 8'h0F
`define SBT_IDX_CTRL 8'h10
`define SBT_IDX_ENABLES 8'h8C
// compare unit registers
`define SBT_IDX_CMP_LO 8'h15
`define SBT_IDX_CMP_HI 8'h16
`define SBT_IDX_CMP_CTL 8'h17
// reset cause register: bit 0 power-on, bit 1 brown-out (write 1 to clear)
`define SBT_IDX_RST_CAUSE 8'h20
// field positions
`define SBT_CTRL_RUN 0
`define SBT_CTRL_CSEL 1
`define SBT_CTRL_NOSYNC 2
`define SBT_CTRL_OSCEN 3
`define SBT_CTRL_PS_LO 4
`define SBT_CTRL_MASK 8'h3F
`define SBT_FLAG_OVF 0
`define SBT_FLAG_CMP 2
`define SBT_FLAGS_MASK 8'hF7
`define SBT_CMP_MODE_SPECIAL 4'hB
`define SBT_CMP_CTL_MASK 8'h3F
`define SBT_RESET_BYTE 8'h00
`define SBT_FOSC_DIV 2'h3
`endif

/* File: logic/sbt_pkg.sv */
// types shared by the sixteen bit timer counter
package sbt_pkg;
	typedef struct packed {
		logic [1:0] prescale_field;
		logic oscillator_enable;
		logic sync_disable;
		logic clock_source_select;
		logic run_bit;
	} sbt_ctrl_type;
	typedef struct packed {
		logic [7:0] count_high_byte;
		logic [7:0] count_low_byte;
	} sbt_count_type;
	typedef enum logic [1:0] {
		SBT_SRC_OFF = 2'b00,
		SBT_SRC_INT = 2'b01,
		SBT_SRC_SYNC = 2'b10,
		SBT_SRC_ASYNC = 2'b11
	} sbt_src_type;
endpackage

/* File: logic/sbt_prescaler.sv */
// count-input prescaler: 1/2/4/8 divider with a software clear
`timescale 1ns/1ps
`default_nettype none
module sbt_prescaler
	import sbt_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic clear,
	input wire logic tick_in,
	input wire logic [1:0] ratio,
	// result
	output logic tick_out
);
	logic [2:0] cnt_q;
	logic [2:0] limit;

	always_comb begin
		case (ratio)
			2'b11: limit = 3'h7;
			2'b10: limit = 3'h3;
			2'b01: limit = 3'h1;
			default: limit = 3'h0;
		endcase
	end

	// registered pulse, so the counter steps one cycle after the input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			tick_out <= 1'b0;
		end else if (clear) begin
			cnt_q <= 3'h0;
			tick_out <= 1'b0;
		end else if (tick_in) begin
			tick_out <= (cnt_q == limit);
			cnt_q <= (cnt_q == limit) ? 3'h0 : cnt_q + 3'h1;
		end else begin
			tick_out <= 1'b0;
		end
	end
endmodule // sbt_prescaler
`default_nettype wire

/* File: logic/sbt_timer.sv */
// sixteen bit timer counter with APB register access
//
// Contract
// - counter counts up and wraps to zero
// - wrap latches overflow flag bit 0
// - interrupt only while overflow enable set
// - control bit 1 selects external edges
// - advance per instruction cycle or edge
// - run bit gates counting, holds value
// - prescale field divides by 1/2/4/8
// - oscillator enable forces both pins input
// - oscillator keeps running during sleep
// - special event trigger clears counter
// - trigger clear never sets overflow flag
// - counter write beats coincident trigger clear
// - resets leave counter bytes unchanged
// - power-on or brown-out clears control
// - counter byte write clears prescaler
// - compare match in mode 1011 triggers
//
// Implementation choice: the APB slave port.
`include "sbt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sbt_timer
	import sbt_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset causes, one-cycle pulses
	input wire logic por_pulse,
	input wire logic bor_pulse,
	// core state
	input wire logic sleep_mode,
	// external count pin and its direction bits
	input wire logic external_count_pin,
	input wire logic [1:0] port_direction_in,
	output logic [1:0] port_direction_eff,
	// oscillator, interrupt and special event
	output logic osc_run,
	output logic overflow_irq,
	output logic special_event
);
	// ************************************************************
	// register bus
	// ************************************************************
	sbt_ctrl_type ctrl_q;
	sbt_count_type cnt_q;
	logic [7:0] flags_q;
	logic [7:0] enables_q;
	logic [7:0] intctl_q;
	logic [15:0] cmp_q;
	logic [5:0] cmp_ctl_q;
	logic [1:0] cause_q;
	logic acc;
	logic wr;
	logic rd_hit;
	logic [7:0] idx;
	logic [7:0] rd_val;
	logic [7:0] wbyte;
	// control is six bits wide; the reset byte is cut to fit on purpose
	localparam logic [7:0] CTRL_RST = `SBT_RESET_BYTE;

	function automatic logic hit(input logic [31:0] a, input logic [7:0] i);
		hit = (a[31:10] == 22'h0) && (a[9:2] == i) && (a[1:0] == 2'h0);
	endfunction

	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && pstrb[0];
	assign idx = paddr[9:2];
	assign wbyte = pwdata[7:0];

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 8'h00;
		if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else begin
			case (idx)
				`SBT_IDX_INTCTL: rd_val = intctl_q;
				`SBT_IDX_FLAGS: rd_val = flags_q;
				`SBT_IDX_CNT_LO: rd_val = cnt_q.count_low_byte;
				`SBT_IDX_CNT_HI: rd_val = cnt_q.count_high_byte;
				`SBT_IDX_CTRL: rd_val = {2'h0, ctrl_q};
				`SBT_IDX_ENABLES: rd_val = enables_q;
				`SBT_IDX_CMP_LO: rd_val = cmp_q[7:0];
				`SBT_IDX_CMP_HI: rd_val = cmp_q[15:8];
				`SBT_IDX_CMP_CTL: rd_val = {2'h0, cmp_ctl_q};
				`SBT_IDX_RST_CAUSE: rd_val = {6'h00, cause_q};
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// no wait state: setup, then access completes on the second edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !pready) begin
			prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
			pslverr <= !rd_hit;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	// the apb reset stands for every reset and clears control too, as por/bor pulses do
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= sbt_ctrl_type'(CTRL_RST[5:0]);
		end else if (por_pulse || bor_pulse) begin
			ctrl_q <= sbt_ctrl_type'(CTRL_RST[5:0]);
		end else if (wr && hit(paddr, `SBT_IDX_CTRL)) begin
			ctrl_q <= sbt_ctrl_type'(wbyte[5:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_q <= 2'h0;
		end else begin
			cause_q[0] <= por_pulse ||
				(cause_q[0] && !(wr && hit(paddr, `SBT_IDX_RST_CAUSE) && wbyte[0]));
			cause_q[1] <= bor_pulse ||
				(cause_q[1] && !(wr && hit(paddr, `SBT_IDX_RST_CAUSE) && wbyte[1]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enables_q <= 8'h00;
			intctl_q <= 8'h00;
			cmp_q <= 16'h0000;
			cmp_ctl_q <= 6'h00;
		end else if (wr) begin
			if (hit(paddr, `SBT_IDX_ENABLES))
				enables_q <= wbyte & `SBT_FLAGS_MASK;
			if (hit(paddr, `SBT_IDX_INTCTL))
				intctl_q <= wbyte;
			if (hit(paddr, `SBT_IDX_CMP_LO))
				cmp_q[7:0] <= wbyte;
			if (hit(paddr, `SBT_IDX_CMP_HI))
				cmp_q[15:8] <= wbyte;
			if (hit(paddr, `SBT_IDX_CMP_CTL))
				cmp_ctl_q <= wbyte[5:0];
		end
	end

	// ************************************************************
	// count source
	// ************************************************************
	sbt_src_type src;
	logic [1:0] fosc_q;
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic async_prev_q;
	logic in_tick;
	logic pre_tick;
	logic cnt_wr;

	always_comb begin
		if (!ctrl_q.run_bit)
			src = SBT_SRC_OFF;
		else if (!ctrl_q.clock_source_select)
			src = SBT_SRC_INT;
		else if (ctrl_q.sync_disable)
			src = SBT_SRC_ASYNC;
		else
			src = SBT_SRC_SYNC;
	end

	// instruction cycle: one tick every fourth clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fosc_q <= 2'h0;
		end else begin
			fosc_q <= fosc_q + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
			async_prev_q <= 1'b0;
		end else begin
			sync1_q <= external_count_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			async_prev_q <= external_count_pin;
		end
	end

	// the async path samples the pin once, so it keeps working in sleep
	// but a trigger clear there may race the count, which software avoids
	always_comb begin
		case (src)
			SBT_SRC_INT: in_tick = (fosc_q == `SBT_FOSC_DIV) && !sleep_mode;
			SBT_SRC_SYNC: in_tick = sync2_q && !sync3_q && !sleep_mode;
			SBT_SRC_ASYNC: in_tick = external_count_pin && !async_prev_q;
			default: in_tick = 1'b0;
		endcase
	end

	assign cnt_wr = wr && (hit(paddr, `SBT_IDX_CNT_LO) ||
		hit(paddr, `SBT_IDX_CNT_HI));

	sbt_prescaler u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.clear(cnt_wr),
		.tick_in(in_tick),
		.ratio(ctrl_q.prescale_field),
		.tick_out(pre_tick)
	);

	// ************************************************************
	// counter, compare and flags
	// ************************************************************
	logic trig;
	logic wrap;
	logic cmp_match_q;

	// a match fires once per arrival at the compare value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_match_q <= 1'b0;
		end else begin
			cmp_match_q <= (cnt_q == cmp_q);
		end
	end

	assign trig = (cmp_ctl_q[3:0] == `SBT_CMP_MODE_SPECIAL) &&
		(cnt_q == cmp_q) && !cmp_match_q;
	// a coincident byte write wins, so no rollover happens then
	assign wrap = pre_tick && (cnt_q == 16'hFFFF) && !trig && !cnt_wr;

	// no reset branch: counter bytes keep their value through every reset
	always_ff @(posedge pclk) begin
		if (cnt_wr) begin
			if (hit(paddr, `SBT_IDX_CNT_LO))
				cnt_q.count_low_byte <= wbyte;
			if (hit(paddr, `SBT_IDX_CNT_HI))
				cnt_q.count_high_byte <= wbyte;
		end else if (trig) begin
			cnt_q <= 16'h0000;
		end else if (pre_tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= 8'h00;
		end else begin
			if (wr && hit(paddr, `SBT_IDX_FLAGS))
				flags_q <= wbyte & `SBT_FLAGS_MASK;
			if (wrap)
				flags_q[`SBT_FLAG_OVF] <= 1'b1;
			if (trig)
				flags_q[`SBT_FLAG_CMP] <= 1'b1;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_irq <= 1'b0;
			special_event <= 1'b0;
			osc_run <= 1'b0;
			port_direction_eff <= 2'h3;
		end else begin
			overflow_irq <= flags_q[`SBT_FLAG_OVF] &&
				enables_q[`SBT_FLAG_OVF];
			special_event <= trig;
			osc_run <= ctrl_q.oscillator_enable;
			port_direction_eff <= ctrl_q.oscillator_enable ? 2'h3 :
				port_direction_in;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
		overflow_irq |-> $past(enables_q[0]) && $past(flags_q[0]))
		else $error("overflow irq without enable and flag");
	a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |=> flags_q[0] && cnt_q == 16'h0000)
		else $error("wrap did not set flag or zero counter");
	a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
		trig && !cnt_wr |=> cnt_q == 16'h0000)
		else $error("trigger did not clear counter");
	a_trig_noflag: assert property (@(posedge pclk) disable iff (!presetn)
		trig && !flags_q[0] && !wr |=> !flags_q[0])
		else $error("trigger set overflow flag");
	// counter bytes are unknown until written, so the step is checked instead
	a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_q.run_bit ##1 !ctrl_q.run_bit |-> !pre_tick)
		else $error("counter stepped while stopped");
	a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		pre_tick && !cnt_wr && !trig |=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not step by one");
	a_pre_clear: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_wr |=> !pre_tick)
		else $error("prescaler not cleared by counter write");
	a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_wr && hit(paddr, 8'h0E) |=> cnt_q[7:0] == $past(wbyte))
		else $error("counter write lost");
	a_ctrl_por: assert property (@(posedge pclk) disable iff (!presetn)
		por_pulse || bor_pulse |=> ctrl_q == 6'h00)
		else $error("control not cleared on por or bor");
	a_osc_pins: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q.oscillator_enable ##1 ctrl_q.oscillator_enable |->
		port_direction_eff == 2'h3 && osc_run)
		else $error("pins not forced to input");
	a_int_rate: assert property (@(posedge pclk) disable iff (!presetn)
		src == SBT_SRC_INT && in_tick |=> !in_tick [*3])
		else $error("internal ticks closer than four clocks");
endmodule // sbt_timer
`default_nettype wire

/* File: verification/sbt_ext_src.sv */
// external count source model that drives the count pin in bursts
`timescale 1ns/1ps
`default_nettype none
module sbt_ext_src (
	// clock that times the edges
	input wire logic clk,
	// count pin
	output logic pin
);
	// ****************
	// edge generator
	// ****************
	// the source stands low between bursts, as a stopped clock would
	initial pin = 1'b0;
	// half is counted in clock cycles; the pin moves just after a rising edge
	task automatic burst(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge clk);
			pin <= 1'b1;
			repeat (half) @(posedge clk);
			pin <= 1'b0;
		end
	endtask
endmodule // sbt_ext_src
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the sixteen bit timer counter
`include "sbt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sbt_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
	logic [31:0] paddr, pwdata, prdata;
	logic por_pulse, bor_pulse, sleep_mode, ext_pin, osc_run, serr;
	logic overflow_irq, special_event;
	logic [1:0] dir_eff;
	logic [7:0] rv, r0;
	int err_total, n_tests, n;
	sbt_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .por_pulse(por_pulse),
		.bor_pulse(bor_pulse), .sleep_mode(sleep_mode),
		.external_count_pin(ext_pin), .port_direction_in(2'h1),
		.port_direction_eff(dir_eff), .osc_run(osc_run),
		.overflow_irq(overflow_irq), .special_event(special_event));
	sbt_ext_src xs_u (.clk(pclk), .pin(ext_pin));
	// ****************
	// bus and checks
	// ****************
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		// values read here are those sampled by this rising edge
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) err_total++;
		serr = pslverr;
		rv = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rd(input logic [7:0] idx);
		apb(1'b0, idx, 8'h00);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(ref logic s);
		n = 0;
		while (s !== 1'b1 && n < 400) begin
			@(negedge pclk);
			n++;
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ****************
	// clock, watchdog, tests
	// ****************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#400000;
		err_total++;
		give_verdict();
	end
	initial begin
		{psel, penable, pwrite, por_pulse, bor_pulse, sleep_mode} = '0;
		paddr = 32'h0;
		pwdata = 32'h0;
		err_total = 0;
		n_tests = 0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SBT_IDX_CTRL); chk(rv, 8'h00);
		rd(`SBT_IDX_FLAGS); chk(rv, 8'h00);
		wr(`SBT_IDX_CTRL, 8'hFF);
		rd(`SBT_IDX_CTRL); chk(rv, 8'h3F);
		wr(`SBT_IDX_CTRL, 8'h00);
		rd(8'h7F); chk({7'h0, serr}, 8'h01);
		wr(`SBT_IDX_CNT_LO, 8'h5A);
		wr(`SBT_IDX_CNT_HI, 8'hC3);
		rd(`SBT_IDX_CNT_LO); chk(rv, 8'h5A);
		rd(`SBT_IDX_CNT_HI); chk(rv, 8'hC3);
		// one tick per 4 clocks; bus latency makes the figure +-1
		for (int p = 0; p < 4; p++) begin
			wr(`SBT_IDX_CNT_LO, 8'h00);
			wr(`SBT_IDX_CNT_HI, 8'h00);
			wr(`SBT_IDX_CTRL, {2'h0, 2'(p), 4'h1});
			repeat (320) @(posedge pclk);
			wr(`SBT_IDX_CTRL, 8'h00);
			rd(`SBT_IDX_CNT_LO);
			r0 = 8'(80 >> p);
			chk({7'h0, rv + 1 >= r0 && rv <= r0 + 1}, 8'h01);
		end
		wr(`SBT_IDX_CNT_LO, 8'hFE);
		wr(`SBT_IDX_CNT_HI, 8'hFF);
		wr(`SBT_IDX_ENABLES, 8'h01);
		wr(`SBT_IDX_CTRL, 8'h01);
		wait_hi(overflow_irq); chk({7'h0, overflow_irq}, 8'h01);
		wr(`SBT_IDX_CTRL, 8'h00);
		rd(`SBT_IDX_FLAGS); chk(rv & 8'h01, 8'h01);
		rd(`SBT_IDX_CNT_HI); chk(rv, 8'h00);
		rd(`SBT_IDX_CNT_LO);
		r0 = rv;
		repeat (40) @(posedge pclk);
		rd(`SBT_IDX_CNT_LO); chk(rv, r0);
		wr(`SBT_IDX_ENABLES, 8'h00);
		repeat (2) @(negedge pclk);
		chk({7'h0, overflow_irq}, 8'h00);
		wr(`SBT_IDX_FLAGS, 8'h00);
		wr(`SBT_IDX_CNT_LO, 8'h00);
		wr(`SBT_IDX_CTRL, 8'h03);
		xs_u.burst(5, 4);
		repeat (10) @(posedge pclk);
		rd(`SBT_IDX_CNT_LO); chk(rv, 8'h05);
		wr(`SBT_IDX_CTRL, 8'h0F);
		sleep_mode <= 1'b1;
		// pin outputs follow control one clock after the write lands
		repeat (2) @(negedge pclk);
		chk({6'h0, dir_eff}, 8'h03);
		chk({7'h0, osc_run}, 8'h01);
		xs_u.burst(4, 4);
		repeat (10) @(posedge pclk);
		sleep_mode <= 1'b0;
		wr(`SBT_IDX_CTRL, 8'h00);
		repeat (2) @(negedge pclk);
		chk({6'h0, dir_eff}, 8'h01);
		rd(`SBT_IDX_CNT_LO); chk(rv, 8'h09);
		wr(`SBT_IDX_CNT_LO, 8'h00);
		wr(`SBT_IDX_CMP_LO, 8'h10);
		wr(`SBT_IDX_CMP_HI, 8'h00);
		wr(`SBT_IDX_CMP_CTL, {4'h0, `SBT_CMP_MODE_SPECIAL});
		// timer mode, so the trigger clear is dependable
		wr(`SBT_IDX_CTRL, 8'h01);
		wait_hi(special_event);
		chk({7'h0, special_event}, 8'h01);
		wr(`SBT_IDX_CTRL, 8'h00);
		rd(`SBT_IDX_FLAGS); chk(rv & 8'h05, 8'h04);
		rd(`SBT_IDX_CNT_LO); chk({7'h0, rv < 8'h04}, 8'h01);
		wr(`SBT_IDX_CMP_CTL, 8'h00);
		wr(`SBT_IDX_CNT_LO, 8'hA5);
		for (int k = 0; k < 2; k++) begin
			wr(`SBT_IDX_CTRL, 8'h34);
			por_pulse <= (k == 0);
			bor_pulse <= (k == 1);
			@(posedge pclk);
			{por_pulse, bor_pulse} <= 2'b00;
			rd(`SBT_IDX_CTRL); chk(rv, 8'h00);
		end
		rd(`SBT_IDX_RST_CAUSE); chk(rv, 8'h03);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SBT_IDX_CNT_LO); chk(rv, 8'hA5);
		give_verdict();
	end
endmodule // tb
`default_nettype wire
